// >>> bcd_adjust_bit_logic_unit.sv
`timescale 1ns/10ps
module bcd_adjust_bit_logic_unit
   import bcd_bit_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire cmd_t cmd_i,
   input wire logic cmd_valid_i,
   output logic [7:0] acc_o,
   output logic [7:0] status_o,
   output wb_t wb_o
);
   core_state_t state_reg;
   core_state_t state_next;
   logic [7:0] adj_acc;
   logic adj_carry;
   logic adj_aux;
   logic adj_zero;
   logic [7:0] bit_byte;
   logic bit_carry;
   logic [7:0] bit_result;

   decimal_adjust u_adjust (
      .acc_i(state_reg.acc),
      .carry_i(state_reg.status[CARRY_BIT]),
      .aux_i(state_reg.status[AUX_BIT]),
      .sub_i(cmd_i.op == OP_ADJUST_SUB),
      .acc_o(adj_acc),
      .carry_o(adj_carry),
      .aux_o(adj_aux),
      .zero_o(adj_zero)
   );

   // pick the byte holding the addressed bit; status word bit 6 is the zero flag
   always_comb begin
      if (cmd_i.space == SRC_ACC) begin
         bit_byte = state_reg.acc;
      end else if (cmd_i.space == SRC_STATUS) begin
         bit_byte = state_reg.status;
      end else if (cmd_i.space == SRC_XREG) begin
         bit_byte = cmd_i.ext_byte;
      end else if (cmd_i.space == SRC_SFR) begin
         bit_byte = cmd_i.ext_byte;
      end else begin
         bit_byte = cmd_i.mem_byte;
      end
   end

   bit_operand_unit u_bit (
      .byte_i(bit_byte),
      .bit_sel_i(cmd_i.bit_sel),
      .carry_i(state_reg.status[CARRY_BIT]),
      .op_i(cmd_i.op),
      .invert_i(cmd_i.invert),
      .carry_o(bit_carry),
      .byte_o(bit_result)
   );

   always_comb begin
      state_next = state_reg;
      state_next.wb = '0;
      if (cmd_valid_i) begin
         case (cmd_i.op)
            OP_NIBBLE_ROTATE_LEFT: begin
               // flags and acc high digit are left alone
               state_next.acc = {state_reg.acc[7:4], cmd_i.mem_byte[7:4]};
               state_next.wb.mem_we = 1'b1;
               state_next.wb.mem_data = {cmd_i.mem_byte[3:0], state_reg.acc[3:0]};
            end
            OP_ADJUST_ADD, OP_ADJUST_SUB: begin
               state_next.acc = adj_acc;
               state_next.status[CARRY_BIT] = adj_carry;
               state_next.status[AUX_BIT] = adj_aux;
               state_next.status[ZERO_BIT] = adj_zero;
            end
            OP_MOVE_TO_CARRY, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR: begin
               state_next.status[CARRY_BIT] = bit_carry;
            end
            OP_MOVE_FROM_CARRY: begin
               if (cmd_i.space == SRC_ACC) begin
                  state_next.acc = bit_result;
               end else if (cmd_i.space == SRC_STATUS) begin
                  state_next.status = bit_result;
               end else if (cmd_i.space == SRC_SADDR) begin
                  state_next.wb.mem_we = 1'b1;
                  state_next.wb.mem_data = bit_result;
               end else begin
                  state_next.wb.ext_we = 1'b1;
                  state_next.wb.ext_data = bit_result;
               end
            end
            default: state_next.wb = '0; // unknown op changes nothing, no write pulse
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '{acc: ACC_RESET, status: STATUS_RESET, wb: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign acc_o = state_reg.acc;
   assign status_o = state_reg.status;
   assign wb_o = state_reg.wb;
endmodule : bcd_adjust_bit_logic_unit

// >>> bcd_adjust_bit_logic_unit_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("Error %0t: got %h want %h", $time, a, b); end end
module bcd_adjust_bit_logic_unit_bench
   import bcd_bit_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   cmd_t cmd_i = '0;
   logic [7:0] acc_o;
   logic [7:0] status_o;
   wb_t wb_o;
   wb_t wb_s;
   int failures = 0;
   int cmp_count = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   bcd_adjust_bit_logic_unit DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
      .cmd_valid_i(cmd_valid_i), .acc_o(acc_o), .status_o(status_o), .wb_o(wb_o));
   // one command, write-back pulse captured while it stands
   task automatic issue(op_t op, bit_space_t sp, logic [2:0] sel, logic inv, logic [7:0] mb,
         logic [7:0] eb);
      cmd_i = '{op, sp, sel, inv, mb, eb};
      cmd_valid_i = 1'b1;
      @(negedge sys_clk_i);
      wb_s = wb_o;
      cmd_valid_i = 1'b0;
      @(negedge sys_clk_i);
   endtask : issue
   task automatic setcy(logic c);
      issue(OP_MOVE_TO_CARRY, SRC_SADDR, 3'h0, 1'b0, {8{c}}, 8'h00);
   endtask : setcy
   task automatic load(logic [7:0] v, logic aux, logic carry);
      for (int i = 0; i < 8; i++) begin
         setcy(v[i]);
         issue(OP_MOVE_FROM_CARRY, SRC_ACC, 3'(i), 1'b0, 8'h00, 8'h00);
      end
      setcy(aux);
      issue(OP_MOVE_FROM_CARRY, SRC_STATUS, 3'h4, 1'b0, 8'h00, 8'h00);
      setcy(carry);
   endtask : load
   task automatic t_rotate();
      load(8'h12, 1'b1, 1'b1);
      issue(OP_NIBBLE_ROTATE_LEFT, SRC_SADDR, 3'h0, 1'b0, 8'h34, 8'h00);
      `CHK(acc_o, 8'h13)
      `CHK({wb_s.mem_we, wb_s.mem_data}, 9'h142)
      `CHK({status_o[4], status_o[0], wb_o.mem_we}, 3'h6)
   endtask : t_rotate
   task automatic adj(op_t op, logic [7:0] a, logic aux, logic carry, logic [7:0] ea, logic eaux,
         logic ecarry);
      load(a, aux, carry);
      issue(op, SRC_SADDR, 3'h0, 1'b0, 8'h00, 8'h00);
      `CHK(acc_o, ea)
      `CHK({status_o[6], status_o[4], status_o[0]}, {ea == 8'h00, eaux, ecarry})
   endtask : adj
   task automatic t_logic();
      op_t op;
      logic e;
      load(8'h00, 1'b1, 1'b0);
      for (int k = 0; k < 12; k++) begin
         op = op_t'(4'(6 + k / 4));
         e = 1'b1 ^ (k[1] && op != OP_BIT_XOR);
         e = op == OP_BIT_AND ? k[0] & e : op == OP_BIT_OR ? k[0] | e : k[0] ^ e;
         setcy(k[0]);
         issue(op, SRC_SADDR, 3'h5, k[1], 8'h20, 8'h00);
         `CHK({status_o[4], status_o[0]}, {1'b1, e})
      end
   endtask : t_logic
   task automatic t_move();
      setcy(1'b1);
      issue(OP_MOVE_FROM_CARRY, SRC_SFR, 3'h2, 1'b0, 8'h00, 8'h81);
      `CHK({wb_s.ext_we, wb_s.ext_data}, 9'h185)
      issue(OP_MOVE_FROM_CARRY, SRC_SADDR, 3'h7, 1'b0, 8'h01, 8'h00);
      `CHK({wb_s.mem_we, wb_s.mem_data}, 9'h181)
      setcy(1'b0);
      issue(OP_MOVE_FROM_CARRY, SRC_STATUS, 3'h6, 1'b0, 8'h00, 8'h00);
      `CHK({status_o[6], status_o[4], status_o[0]}, 3'h2)
      setcy(1'b1);
      issue(OP_MOVE_FROM_CARRY, SRC_STATUS, 3'h6, 1'b0, 8'h00, 8'h00);
      `CHK({status_o[6], status_o[4], status_o[0]}, 3'h7)
      issue(OP_BIT_AND, SRC_STATUS, 3'h6, 1'b1, 8'h00, 8'h00);
      `CHK(status_o[0], 1'b0)
      issue(OP_MOVE_TO_CARRY, SRC_XREG, 3'h3, 1'b0, 8'h00, 8'h08);
      `CHK({status_o[6], status_o[0]}, 2'h3)
   endtask : t_move
   task automatic test_done();
      $display("failures=%0d compares=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial begin
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_rotate();
      adj(OP_ADJUST_ADD, 8'h45, 1'b0, 1'b0, 8'h45, 1'b0, 1'b0);
      adj(OP_ADJUST_ADD, 8'ha3, 1'b0, 1'b0, 8'h03, 1'b0, 1'b1);
      adj(OP_ADJUST_ADD, 8'h00, 1'b0, 1'b1, 8'h60, 1'b0, 1'b1);
      adj(OP_ADJUST_ADD, 8'h8a, 1'b0, 1'b0, 8'h90, 1'b1, 1'b0);
      adj(OP_ADJUST_ADD, 8'h12, 1'b1, 1'b0, 8'h18, 1'b1, 1'b0);
      adj(OP_ADJUST_ADD, 8'h9a, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1);
      adj(OP_ADJUST_SUB, 8'h66, 1'b0, 1'b0, 8'h66, 1'b0, 1'b0);
      adj(OP_ADJUST_SUB, 8'h66, 1'b0, 1'b1, 8'h06, 1'b0, 1'b1);
      adj(OP_ADJUST_SUB, 8'h66, 1'b1, 1'b0, 8'h60, 1'b1, 1'b0);
      adj(OP_ADJUST_SUB, 8'h66, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1);
      t_logic();
      t_move();
      test_done();
   end
endmodule : bcd_adjust_bit_logic_unit_bench

// >>> bcd_adjust_bit_logic_unit_checker.sv
`timescale 1ns/10ps
module bcd_adjust_bit_logic_unit_checker
   import bcd_bit_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire cmd_t cmd_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] acc_o,
   input wire logic [7:0] status_o,
   input wire wb_t wb_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire logic rol = cmd_valid_i && cmd_i.op == OP_NIBBLE_ROTATE_LEFT;
   wire logic sub = cmd_valid_i && cmd_i.op == OP_ADJUST_SUB;
   wire logic adj = sub || (cmd_valid_i && cmd_i.op == OP_ADJUST_ADD);
   wire logic lg = cmd_valid_i && cmd_i.op inside {OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR};
   wire logic mv_st = cmd_valid_i && cmd_i.op == OP_MOVE_FROM_CARRY && cmd_i.space == SRC_STATUS;
   wire logic b = cmd_i.mem_byte[cmd_i.bit_sel] ^ (cmd_i.invert && cmd_i.op != OP_BIT_XOR);
   wire logic [1:0] f = {status_o[CARRY_BIT], b};
   wire logic res = cmd_i.op == OP_BIT_AND ? &f : cmd_i.op == OP_BIT_OR ? |f : ^f;
   a_rotate_acc: assert property (rol |=>
      acc_o == {$past(acc_o[7:4]), $past(cmd_i.mem_byte[7:4])}) else $error("rotate acc");
   a_rotate_mem: assert property (rol |=> wb_o.mem_we &&
      wb_o.mem_data == {$past(cmd_i.mem_byte[3:0]), $past(acc_o[3:0])}) else $error("rotate mem");
   a_rotate_flags: assert property (rol |=> $stable(status_o)) else $error("rotate flags");
   a_adjust_zero: assert property (adj |=> status_o[ZERO_BIT] == (acc_o == 8'h00))
      else $error("adjust zero");
   a_sub_value: assert property (sub |=> $stable({status_o[AUX_BIT], status_o[CARRY_BIT]}) &&
      acc_o == $past(acc_o) - (({8{$past(status_o[CARRY_BIT])}} & ADJ_HIGH) |
      ({8{$past(status_o[AUX_BIT])}} & ADJ_LOW))) else $error("sub adjust");
   a_logic_carry: assert property (lg && cmd_i.space == SRC_SADDR |=>
      status_o[CARRY_BIT] == $past(res)) else $error("bit logic carry");
   a_logic_only: assert property (lg |=> $stable(status_o[7:1]) && $stable(acc_o))
      else $error("bit logic flags");
   a_move_one: assert property (cmd_valid_i && cmd_i.op == OP_MOVE_TO_CARRY |=>
      $stable(status_o[7:1])) else $error("move flags");
   a_move_status: assert property (mv_st |=>
      ((status_o ^ $past(status_o)) & ~(8'h01 << $past(cmd_i.bit_sel))) == 8'h00 &&
      status_o[$past(cmd_i.bit_sel)] == $past(status_o[CARRY_BIT])) else $error("move status");
   c_rotate: cover property (rol);
   c_sub: cover property (sub && status_o[AUX_BIT] && status_o[CARRY_BIT]);
   c_invert: cover property (lg && cmd_i.invert);
endmodule : bcd_adjust_bit_logic_unit_checker
bind bcd_adjust_bit_logic_unit bcd_adjust_bit_logic_unit_checker u_chk (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .acc_o(acc_o), .status_o(status_o),
   .wb_o(wb_o));

// >>> bcd_bit_pkg.sv
// Contract
// - nibble rotate left turns A low digit and memory byte as one 12-bit circle.
// - A low gets mem high, mem low gets old A low, mem high gets old mem low.
// - nibble rotate left keeps the accumulator's upper four bits unchanged.
// - add adjust: both digits decimal, flags clear: A kept, carry and aux cleared.
// - add adjust: low ok, high over 9 or carry: add 60h, carry set, aux clear.
// - add adjust: low digit correction only adds 06h, carry clear, aux set.
// - add adjust: both digits corrected adds 66h, carry and aux set.
// - sub adjust: aux and carry select subtracting 00h, 60h, 06h or 66h; aux and carry kept.
// - after either adjust the zero flag shows whether the accumulator is zero.
// - single bit move copies a bit between carry and any bit source, both ways.
// - a move into carry or a status bit alters only that one flag.
// - single bit and replaces carry with carry AND source bit.
// - inverted form of single bit and inverts the source bit first.
// - single bit or replaces carry with carry OR source bit.
// - inverted form of single bit or inverts the source bit first.
// - single bit xor replaces carry with carry XOR source bit; no inverted form.
// - bit and, or, xor write carry only; zero and aux carry untouched.
// - status word bit 6 addresses the zero flag.
package bcd_bit_pkg;
   localparam logic [7:0] ADJ_NONE = 8'h00;
   localparam logic [7:0] ADJ_HIGH = 8'h60;
   localparam logic [7:0] ADJ_LOW = 8'h06;
   localparam logic [7:0] ADJ_BOTH = 8'h66;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int ZERO_BIT = 6;
   localparam int AUX_BIT = 4;
   localparam int CARRY_BIT = 0;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_NIBBLE_ROTATE_LEFT = 4'h1,
      OP_ADJUST_ADD = 4'h2,
      OP_ADJUST_SUB = 4'h3,
      OP_MOVE_TO_CARRY = 4'h4,
      OP_MOVE_FROM_CARRY = 4'h5,
      OP_BIT_AND = 4'h6,
      OP_BIT_OR = 4'h7,
      OP_BIT_XOR = 4'h8
   } op_t;

   typedef enum logic [2:0] {
      SRC_SADDR = 3'h0,
      SRC_SFR = 3'h1,
      SRC_ACC = 3'h2,
      SRC_XREG = 3'h3,
      SRC_STATUS = 3'h4
   } bit_space_t;

   typedef struct packed {
      op_t op;
      bit_space_t space;
      logic [2:0] bit_sel;
      logic invert;
      logic [7:0] mem_byte;
      logic [7:0] ext_byte;
   } cmd_t;

   typedef struct packed {
      logic mem_we;
      logic [7:0] mem_data;
      logic ext_we;
      logic [7:0] ext_data;
   } wb_t;

   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] status;
      wb_t wb;
   } core_state_t;
endpackage : bcd_bit_pkg

// >>> bit_operand_unit.sv
`timescale 1ns/10ps
module bit_operand_unit
   import bcd_bit_pkg::*;
(
   input wire logic [7:0] byte_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic carry_i,
   input wire op_t op_i,
   input wire logic invert_i,
   output logic carry_o,
   output logic [7:0] byte_o
);
   logic src;
   always_comb begin
      src = byte_i[bit_sel_i];
      carry_o = carry_i;
      byte_o = byte_i;
      case (op_i)
         OP_MOVE_TO_CARRY: carry_o = src;
         OP_MOVE_FROM_CARRY: byte_o[bit_sel_i] = carry_i;
         OP_BIT_AND: carry_o = carry_i & (src ^ invert_i);
         OP_BIT_OR: carry_o = carry_i | (src ^ invert_i);
         OP_BIT_XOR: carry_o = carry_i ^ src;
         default: carry_o = carry_i;
      endcase
   end
endmodule : bit_operand_unit

// >>> decimal_adjust.sv
`timescale 1ns/10ps
module decimal_adjust
   import bcd_bit_pkg::*;
(
   input wire logic [7:0] acc_i,
   input wire logic carry_i,
   input wire logic aux_i,
   input wire logic sub_i,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic aux_o,
   output logic zero_o
);
   logic lo_big;
   logic hi_big;
   logic hi_nine;
   logic [7:0] corr;
   always_comb begin
      lo_big = acc_i[3:0] > DIGIT_MAX;
      hi_big = acc_i[7:4] > DIGIT_MAX;
      hi_nine = acc_i[7:4] >= DIGIT_MAX;
      corr = ADJ_NONE;
      carry_o = 1'b0;
      aux_o = 1'b0;
      if (sub_i) begin
         carry_o = carry_i;
         aux_o = aux_i;
         corr = {(carry_i ? ADJ_HIGH[7:4] : 4'h0), (aux_i ? ADJ_LOW[3:0] : 4'h0)};
         acc_o = acc_i - corr;
      end else begin
         if (!aux_i && !lo_big) begin
            if (hi_big || carry_i) begin
               corr = ADJ_HIGH;
               carry_o = 1'b1;
            end
         end else if (!aux_i) begin
            aux_o = 1'b1;
            if (hi_nine || carry_i) begin
               corr = ADJ_BOTH;
               carry_o = 1'b1;
            end else begin
               corr = ADJ_LOW;
            end
         end else begin
            aux_o = 1'b1;
            if (hi_big || carry_i) begin
               corr = ADJ_BOTH;
               carry_o = 1'b1;
            end else begin
               corr = ADJ_LOW;
            end
         end
         acc_o = acc_i + corr;
      end
      zero_o = (acc_o == 8'h00);
   end
endmodule : decimal_adjust
